// File: pkg/stpcs_defs.vh
// Constants for the shared timer prescaler and clock select block.
// Assumes inclusion by the single design file; definitions only.
`ifndef STPCS_DEFS_VH
`define STPCS_DEFS_VH

// ==========================================================
// Register map (byte addresses on the AXI4-Lite slave)
`define STPCS_ADDR_W        9
// Sync control sits at four times its index; the other two follow it
`define STPCS_OFF_GSYNC     9'h10C
`define STPCS_OFF_CLKSEL    9'h110
`define STPCS_OFF_STATUS    9'h114
// Printed offset of the sync control register, kept as its index
`define STPCS_IDX_GSYNC     8'h43

// ==========================================================
// Sync control fields
`define STPCS_BIT_HOLD      7
`define STPCS_BIT_ASYNCRST  1
`define STPCS_BIT_SHARERST  0
`define STPCS_GSYNC_RESET   8'h00

// ==========================================================
// Clock select field layout and codes
`define STPCS_CS_W          3
`define STPCS_CS0_LSB       0
`define STPCS_CS1_LSB       4
`define STPCS_CS_STOP       3'h0
`define STPCS_CS_DIRECT     3'h1
`define STPCS_CS_DIV8       3'h2
`define STPCS_CS_DIV64      3'h3
`define STPCS_CS_DIV256     3'h4
`define STPCS_CS_DIV1024    3'h5
`define STPCS_CS_EXTFALL    3'h6
`define STPCS_CS_EXTRISE    3'h7

// ==========================================================
// Prescaler taps (terminal count per divisor, 10-bit counter)
`define STPCS_PRE_W         10
`define STPCS_TAP8          10'h007
`define STPCS_TAP64         10'h03F
`define STPCS_TAP256        10'h0FF
`define STPCS_TAP1024       10'h3FF

// ==========================================================
// AXI responses
`define STPCS_RESP_OKAY     2'h0
`define STPCS_RESP_SLVERR   2'h2

`endif

// File: rtl/stpcs_prescaler.v
// Shared free-running prescaler and per-timer clock select for two timers.
// Assumes one 250 MHz clock, software on AXI4-Lite, external count pins
// asynchronous to clk_sys.
`timescale 1ns/1ps
`include "stpcs_defs.vh"

module stpcs_prescaler #(
	parameter PRE_W = `STPCS_PRE_W
) (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire        clkEn,
	input  wire [1:0]  externalCountPin,
	output reg  [1:0]  timerCountClock,
	output reg         asyncPrescalerReset,
	input  wire [`STPCS_ADDR_W-1:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [`STPCS_ADDR_W-1:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ==========================================================
	// Sizes
	localparam N_TIMER = 2;
	localparam N_TAP   = 4;

	// ==========================================================
	// Registers
	reg                syncHoldMode;
	reg                sharedPrescalerReset;
	reg                asyncResetBit;
	reg  [2:0]         clockSourceField0;
	reg  [2:0]         clockSourceField1;
	reg  [PRE_W-1:0]   preCount;
	reg  [`STPCS_ADDR_W-1:0] awAddr;
	reg                awHeld;
	reg  [31:0]        wData;
	reg  [3:0]         wStrb;
	reg                wHeld;
	reg  [31:0]        readWord;
	reg  [1:0]         readResp;
	wire [N_TIMER-1:0] gatedTick;

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	wire doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire wrGsync = doWrite && (awAddr == `STPCS_OFF_GSYNC) && wStrb[0];
	wire wrSel   = doWrite && (awAddr == `STPCS_OFF_CLKSEL) && wStrb[0];
	wire wrKnown = (awAddr == `STPCS_OFF_GSYNC) || (awAddr == `STPCS_OFF_CLKSEL)
		|| (awAddr == `STPCS_OFF_STATUS);

	// Address side, held until the response goes out
	always @(posedge clk_sys) begin
		if (reset) begin
			awHeld <= 1'b0;
			awAddr <= {`STPCS_ADDR_W{1'b0}};
		end else if (clkEn) begin
			if (doWrite) begin
				awHeld <= 1'b0;
			end else if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
		end
	end

	// Data side, held until the response goes out
	always @(posedge clk_sys) begin
		if (reset) begin
			wHeld <= 1'b0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else if (clkEn) begin
			if (doWrite) begin
				wHeld <= 1'b0;
			end else if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
		end
	end

	// Response stands until the master takes it
	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `STPCS_RESP_OKAY;
		end else if (clkEn) begin
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrKnown ? `STPCS_RESP_OKAY : `STPCS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Handshake readies, one-cycle pulses
	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
		end else if (clkEn) begin
			s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_wready <= 1'b0;
		end else if (clkEn) begin
			s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
		end
	end

	// No new address while a read answer still stands
	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
		end else if (clkEn) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
		end
	end

	// ==========================================================
	// Sync control register
	always @(posedge clk_sys) begin
		if (reset) begin
			syncHoldMode <= 1'b0;
		end else if (clkEn && wrGsync) begin
			syncHoldMode <= wData[`STPCS_BIT_HOLD];
		end
	end

	// Written value stands one cycle, or for as long as hold is set
	always @(posedge clk_sys) begin
		if (reset) begin
			sharedPrescalerReset <= 1'b0;
		end else if (clkEn) begin
			if (wrGsync) begin
				sharedPrescalerReset <= wData[`STPCS_BIT_SHARERST];
			end else if (!syncHoldMode) begin
				sharedPrescalerReset <= 1'b0;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			asyncResetBit <= 1'b0;
		end else if (clkEn) begin
			if (wrGsync) begin
				asyncResetBit <= wData[`STPCS_BIT_ASYNCRST];
			end else if (!syncHoldMode) begin
				asyncResetBit <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Clock select register
	always @(posedge clk_sys) begin
		if (reset) begin
			clockSourceField0 <= `STPCS_CS_STOP;
			clockSourceField1 <= `STPCS_CS_STOP;
		end else if (clkEn && wrSel) begin
			clockSourceField0 <= wData[`STPCS_CS0_LSB +: `STPCS_CS_W];
			clockSourceField1 <= wData[`STPCS_CS1_LSB +: `STPCS_CS_W];
		end
	end

	// ==========================================================
	// Read word select; unmapped addresses read zero with an error
	always @* begin
		readWord = 32'h00000000;
		readResp = `STPCS_RESP_OKAY;
		case (s_axi_araddr)
		`STPCS_OFF_GSYNC: begin
			readWord = {24'h000000, syncHoldMode, 5'h00,
				asyncResetBit, sharedPrescalerReset};
		end
		`STPCS_OFF_CLKSEL: begin
			readWord = {25'h0000000, clockSourceField1, 1'b0,
				clockSourceField0};
		end
		`STPCS_OFF_STATUS: begin
			readWord = {20'h00000, 2'h0, preCount};
		end
		default: begin
			readResp = `STPCS_RESP_SLVERR;
		end
		endcase
	end

	// ==========================================================
	// AXI4-Lite read path
	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `STPCS_RESP_OKAY;
		end else if (clkEn) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= readWord;
				s_axi_rresp  <= readResp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Shared prescaler, never touched by the clock selects
	// A tap fires when its low counter bits are all ones; smallest first
	wire [N_TAP*PRE_W-1:0] tapMask = {`STPCS_TAP1024, `STPCS_TAP256,
		`STPCS_TAP64, `STPCS_TAP8};
	wire [N_TAP-1:0]       tapTick;
	genvar j;
	generate
		for (j = 0; j < N_TAP; j = j + 1) begin : gTap
			wire [PRE_W-1:0] mask = tapMask[j*PRE_W +: PRE_W];
			assign tapTick[j] = (preCount & mask) == mask;
		end
	endgenerate
	wire             tick8    = tapTick[0];
	wire             tick64   = tapTick[1];
	wire             tick256  = tapTick[2];
	wire             tick1024 = tapTick[3];

	always @(posedge clk_sys) begin
		if (reset) begin
			preCount <= {PRE_W{1'b0}};
		end else if (clkEn) begin
			if (sharedPrescalerReset) begin
				preCount <= {PRE_W{1'b0}};
			end else begin
				preCount <= preCount + 1'b1;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			asyncPrescalerReset <= 1'b0;
		end else if (clkEn) begin
			asyncPrescalerReset <= asyncResetBit;
		end
	end

	// ==========================================================
	// Per timer pin synchroniser, edge detector and select
	// Negative-phase latch is folded into the first stage: a rising-edge
	// chain gives the same 2.5..3.5 cycle window at this rate.
	genvar t;
	generate
		for (t = 0; t < N_TIMER; t = t + 1) begin : gTimer
			reg  [2:0] pinSync;
			reg        pinPrev;
			wire [2:0] sel = (t == 0) ? clockSourceField0 : clockSourceField1;
			reg        next_tick;

			wire agreed = (pinSync[1] == pinSync[2]);

			// Only the last two stages are compared; the first may be metastable
			always @(posedge clk_sys) begin
				if (reset) begin
					pinSync <= 3'h0;
				end else if (clkEn) begin
					pinSync <= {pinSync[1:0], externalCountPin[t]};
				end
			end

			// Reset low matches an idle pin, so no false edge after reset
			always @(posedge clk_sys) begin
				if (reset) begin
					pinPrev <= 1'b0;
				end else if (clkEn && agreed) begin
					pinPrev <= pinSync[2];
				end
			end
			wire rise   = agreed && pinSync[2] && !pinPrev;
			wire fall   = agreed && !pinSync[2] && pinPrev;

			always @* begin
				case (sel)
				`STPCS_CS_STOP:     next_tick = 1'b0;
				`STPCS_CS_DIRECT:   next_tick = 1'b1;
				`STPCS_CS_DIV8:     next_tick = tick8;
				`STPCS_CS_DIV64:    next_tick = tick64;
				`STPCS_CS_DIV256:   next_tick = tick256;
				`STPCS_CS_DIV1024:  next_tick = tick1024;
				`STPCS_CS_EXTFALL:  next_tick = fall;
				`STPCS_CS_EXTRISE:  next_tick = rise;
				default:            next_tick = 1'b0;
				endcase
			end

			// Only prescaled ticks are held off; direct and pin clocks bypass
			assign gatedTick[t] = next_tick && !(sharedPrescalerReset
				&& sel >= `STPCS_CS_DIV8 && sel <= `STPCS_CS_DIV1024);
		end
	endgenerate

	// ==========================================================
	// Timer clock outputs, each pulse stands one cycle
	always @(posedge clk_sys) begin
		if (reset) begin
			timerCountClock <= 2'h0;
		end else if (clkEn) begin
			timerCountClock <= gatedTick;
		end
	end

endmodule // stpcs_prescaler

// File: tb/stpcs_ext_source.sv
// Model of the clock source on a timer count pin.
// Assumes the bench gives run and the half period in cycles.
`timescale 1ns/1ps
module stpcs_ext_source (
	input  wire logic       clk_sys,
	input  wire logic       run,
	input  wire logic [3:0] half,
	output logic            pin
);
	logic [3:0] cnt;
	initial begin
		pin = 1'h0;
		cnt = 4'h0;
	end
	// Half period of 3 or more cycles stays under clk/2.5
	always @(posedge clk_sys) begin
		if (!run)
			cnt <= 4'h0;
		else if (cnt + 4'h1 >= half) begin
			cnt <= 4'h0;
			pin <= !pin;
		end else
			cnt <= cnt + 4'h1;
	end
endmodule // stpcs_ext_source

// File: tb/stpcs_props.sv
// Checker on the prescaler ports.
// Assumes one clock; bound into stpcs_prescaler below.
`timescale 1ns/1ps
module stpcs_props (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [1:0]  externalCountPin,
	input wire logic [1:0]  timerCountClock,
	input wire logic        asyncPrescalerReset,
	input wire logic [8:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready
);
	reg  [6:0] sel;
	reg        hold;
	reg        pinPrev;
	reg  [3:0] still;
	wire       wrEv = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// Shadow lags less than the design, so selections are held a few cycles
	always @(posedge clk_sys) begin
		pinPrev <= externalCountPin[1];
		if (reset) begin
			sel <= 7'h00;
			hold <= 1'h0;
		end else if (wrEv && s_axi_wstrb[0] && s_axi_awaddr == 9'h110)
			sel <= s_axi_wdata[6:0];
		else if (wrEv && s_axi_wstrb[0] && s_axi_awaddr == 9'h10C)
			hold <= s_axi_wdata[7];
		if (reset || externalCountPin[1] != pinPrev)
			still <= 4'h0;
		else if (still != 4'hF)
			still <= still + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence selHeld(c);
		(sel[2:0] == c)[*4];
	endsequence
	sequence div8Tick;
		selHeld(3'h2) ##0 timerCountClock[0];
	endsequence
	a_stop_quiet: assert property (selHeld(3'h0) |-> !timerCountClock[0])
		else $error("stopped timer ticked");
	a_direct_every: assert property (selHeld(3'h1) |-> timerCountClock[0])
		else $error("direct clock missed a tick");
	a_div8_period: assert property (div8Tick |->
		##1 (!timerCountClock[0] || sel[2:0] != 3'h2)[*7]
		##1 (timerCountClock[0] || sel[2:0] != 3'h2))
		else $error("divide by 8 period wrong");
	a_ext_rise: assert property ($rose(externalCountPin[1]) && sel[6:4] == 3'h7
		|-> ##[2:5] timerCountClock[1])
		else $error("rising pin edge not counted");
	a_ext_fall: assert property ($fell(externalCountPin[1]) && sel[6:4] == 3'h6
		|-> ##[2:5] timerCountClock[1])
		else $error("falling pin edge not counted");
	a_ext_quiet: assert property ((sel[6:4] == 3'h7)[*3] ##0 still == 4'hF
		|-> !timerCountClock[1])
		else $error("tick without pin edge");
	a_hold_keeps: assert property (hold && asyncPrescalerReset && !wrEv
		|=> asyncPrescalerReset)
		else $error("held reset bit dropped");
	a_hold_clear: assert property (wrEv && s_axi_awaddr == 9'h10C && !s_axi_wdata[7]
		|-> ##[2:5] !asyncPrescalerReset)
		else $error("reset bit not cleared");
endmodule // stpcs_props
bind stpcs_prescaler stpcs_props u_props (.clk_sys, .reset, .externalCountPin,
	.timerCountClock, .asyncPrescalerReset, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready);

// File: tb/tb_shared_timer_prescaler_clock_select.sv
// Bench for the shared prescaler and clock select.
// Assumes the source model and the checker are compiled first.
`timescale 1ns/1ps
module tb_shared_timer_prescaler_clock_select;
	logic        clk_sys = 1'h0, reset = 1'h1, run = 1'h0, pin1;
	logic [1:0]  tcc, bresp, rresp, rdResp;
	logic        apr, awready, wready, bvalid, arready, rvalid;
	logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
	logic [8:0]  awaddr = 9'h000, araddr = 9'h000;
	logic [31:0] wdata = 32'h0, rdata, rdVal;
	int          n_errors = 0, comparisons = 0, cyc = 0, w;
	int          n0 = 0, n1 = 0, s0, s1, e, rises = 0, falls = 0;
	int          taps[6] = '{0, 1024, 128, 16, 4, 1};
	stpcs_ext_source SRC (.clk_sys(clk_sys), .run(run), .half(4'h3), .pin(pin1));
	stpcs_prescaler DUT (.clk_sys(clk_sys), .reset(reset), .clkEn(1'h1),
		.externalCountPin({pin1, pin1}), .timerCountClock(tcc),
		.asyncPrescalerReset(apr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1));
	initial begin
		forever #2 clk_sys = !clk_sys;
	end
	always @(posedge clk_sys) begin
		n0 <= n0 + tcc[0];
		n1 <= n1 + tcc[1];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	always @(posedge pin1) rises++;
	always @(negedge pin1) falls++;
	task check(input string nm, input logic [31:0] x, input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	task wr(input logic [8:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!bvalid);
	endtask
	task rd(input logic [8:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (arready)
				arvalid <= 1'h0;
		end while (!rvalid);
		rdVal = rdata;
		rdResp = rresp;
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'h0;
		@(posedge clk_sys);
		rd(9'h10C);
		check("sync reset value", 32'h0, rdVal);
		rd(9'h118);
		check("unmapped resp", 32'h2, 32'(rdResp));
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			wr(9'h110, 32'(((5 - i) << 4) | i));
			repeat (8) @(posedge clk_sys);
			s0 = n0;
			s1 = n1;
			repeat (1024) @(posedge clk_sys);
			check("timer0 ticks", 32'(taps[i]), 32'(n0 - s0));
			check("timer1 ticks", 32'(taps[5 - i]), 32'(n1 - s1));
		end
		$display("test clock select done");
		wr(9'h10C, 32'h1);
		rd(9'h114);
		check("prescaler restarted", 32'h1, 32'(rdVal < 32'h10));
		rd(9'h10C);
		check("shared reset cleared", 32'h0, rdVal);
		$display("test prescaler reset done");
		wr(9'h10C, 32'h83);
		wr(9'h110, 32'h22);
		s0 = n0;
		s1 = n1;
		repeat (100) @(posedge clk_sys);
		rd(9'h10C);
		check("hold kept", 32'h83, rdVal);
		check("held ticks", 32'h0, 32'(n0 - s0 + n1 - s1));
		check("async reset held", 32'h1, 32'(apr));
		wr(9'h10C, 32'h0);
		for (w = 0; tcc === 2'h0 && w < 20; w++)
			@(posedge clk_sys);
		check("start together", 32'h3, 32'(tcc));
		check("first tick delay", 32'h1, 32'(w >= 1 && w <= 9));
		check("async reset cleared", 32'h0, 32'(apr));
		$display("test sync hold done");
		for (int k = 0; k < 2; k++) begin
			wr(9'h110, 32'(7 - k) << 4);
			s0 = n0;
			s1 = n1;
			e = k ? falls : rises;
			run <= 1'h1;
			repeat (120) @(posedge clk_sys);
			run <= 1'h0;
			repeat (12) @(posedge clk_sys);
			check("edge ticks", 32'((k ? falls : rises) - e), 32'(n1 - s1));
			check("stopped timer0", 32'h0, 32'(n0 - s0));
		end
		$display("test external clock done");
		stop_test();
	end
endmodule // tb_shared_timer_prescaler_clock_select
